// *** include/fes_params.svh ***
`ifndef FES_PARAMS_SVH
`define FES_PARAMS_SVH

// ----------------------------------------
// Command bytes
// ----------------------------------------
`define FES_CMD_ERASE_4K 8'h20
`define FES_CMD_ERASE_32K 8'h52
`define FES_CMD_ERASE_64K 8'hd8
`define FES_CMD_CHIP_A 8'h60
`define FES_CMD_CHIP_B 8'hc7
`define FES_CMD_SUSPEND 8'hb0
`define FES_CMD_RESUME 8'hd0

// ----------------------------------------
// Address layout
// ----------------------------------------
`define FES_ADDR_W 24
`define FES_SECTOR_LSB 16
`define FES_SECTOR_W 5
`define FES_MASK_4K 24'hfff000
`define FES_MASK_32K 24'hff8000
`define FES_MASK_64K 24'hff0000
`define FES_ADDR_BYTES 3

// ----------------------------------------
// Timing, times in microseconds
// ----------------------------------------
`define FES_CLK_MHZ 10
`define FES_BLOCK_ERASE_TIME_US 1000
`define FES_CHIP_ERASE_TIME_US 20000
`define FES_PROG_TIME_US 1000
`define FES_SUSPEND_LATENCY_US 20
`define FES_RESUME_LATENCY_US 20

`endif

// *** include/fes_pkg.sv ***
package fes_pkg;

   // Sequencer states
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_RUN,
      ST_SUSP_WAIT,
      ST_RES_WAIT
   } fes_state_e;

   // Erase extent
   typedef enum logic [1:0] {
      KIND_4K,
      KIND_32K,
      KIND_64K,
      KIND_CHIP
   } fes_kind_e;

   // Status flags seen by status reads
   typedef struct packed {
      logic ready_busy_flag;
      logic write_enable_latch;
      logic erase_program_error_flag;
      logic program_suspended_flag;
      logic erase_suspended_flag;
   } fes_status_s;

   // Erase order to the array
   typedef struct packed {
      logic valid;
      fes_kind_e kind;
      logic [23:0] addr;
   } fes_erase_cmd_s;

endpackage : fes_pkg

// *** hw/fes_erase_suspend.sv ***
`timescale 1ns/1ns
`include "fes_params.svh"
// What this block does
// - 20h/52h/D8h erase 4K/32K/64K blocks to ones
// - Erase starts only with latch already set
// - Three address bytes, extra bytes ignored
// - Erase starts at deselect, self-timed
// - Low address bits ignored per block size
// - Short address or ragged deselect aborts erase
// - Protected or locked target not erased
// - Those aborts clear the write enable latch
// - Busy during erase, latch cleared before end
// - Failed erase sets the error flag
// - 60h and C7h both erase whole chip
// - Chip erase takes no address, self-timed
// - Protection or ragged deselect refuses chip erase
// - B0h suspend, latch state irrelevant
// - Suspend halts within latency, sets flag, ready
// - Incomplete or ragged suspend does nothing
// - Suspend covers one 64KB sector only
// - Reads of suspended sector return undefined data
// - Sequential read undefined while in suspended sector
// - Program to erase-suspended sector aborts, clears latch
// - Erase to program-suspended sector aborts, clears latch
// - Program allowed during erase suspend, both flags
// - D0h resume, flag cleared after latency, busy
// - Resume restarts program before erase
// - Other disallowed commands during suspend leave latch alone
module fes_erase_suspend #(
   parameter int BLK_ERASE_CYC = `FES_BLOCK_ERASE_TIME_US * `FES_CLK_MHZ,
   parameter int CHIP_ERASE_CYC = `FES_CHIP_ERASE_TIME_US * `FES_CLK_MHZ,
   parameter int PROG_CYC = `FES_PROG_TIME_US * `FES_CLK_MHZ
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic cs_n_pin,
   input wire logic sck_pin,
   input wire logic si_pin,
   input wire logic [31:0] sector_protected,
   input wire logic wen_set,
   input wire logic prog_start,
   input wire logic [23:0] prog_addr,
   input wire logic array_fail,
   input wire logic [23:0] rd_addr,
   output fes_pkg::fes_status_s status,
   output fes_pkg::fes_erase_cmd_s erase_cmd,
   output logic prog_abort,
   output logic rd_undefined
);
   import fes_pkg::*;

   localparam int SUSP_CYC = `FES_SUSPEND_LATENCY_US * `FES_CLK_MHZ;
   localparam int RES_CYC = `FES_RESUME_LATENCY_US * `FES_CLK_MHZ;
   localparam int SW = `FES_SECTOR_W;

   // ----------------------------------------
   // Pin synchronisers and serial shifter
   // ----------------------------------------
   logic cs_s1_q, cs_s2_q, cs_s3_q;
   logic sck_s1_q, sck_s2_q, sck_s3_q;
   logic si_s1_q, si_s2_q;
   logic [7:0] sh_q;
   logic [2:0] bit_q;
   logic [2:0] nbytes_q;
   logic [7:0] opc_q;
   logic [23:0] addr_q;

   wire sck_rise = sck_s2_q & ~sck_s3_q & ~cs_s2_q;
   wire cs_fall = ~cs_s2_q & cs_s3_q;
   wire cs_rise = cs_s2_q & ~cs_s3_q;
   wire [7:0] byte_in = {sh_q[6:0], si_s2_q};
   wire byte_done = sck_rise & (bit_q == 3'h7);

   // Two-flop synchronisers, first stage read only by second
   always_ff @(posedge clk) begin
      if (srst) begin
         {cs_s1_q, cs_s2_q, cs_s3_q} <= 3'h7;
         {sck_s1_q, sck_s2_q, sck_s3_q} <= 3'h0;
         {si_s1_q, si_s2_q} <= 2'h0;
      end else begin
         {cs_s1_q, cs_s2_q, cs_s3_q} <= {cs_n_pin, cs_s1_q, cs_s2_q};
         {sck_s1_q, sck_s2_q, sck_s3_q} <= {sck_pin, sck_s1_q, sck_s2_q};
         {si_s1_q, si_s2_q} <= {si_pin, si_s1_q};
      end
   end

   // Shift in MSB first on each rising serial clock
   always_ff @(posedge clk) begin
      if (srst || cs_fall) begin
         sh_q <= 8'h00;
         bit_q <= 3'h0;
         nbytes_q <= 3'h0;
      end else if (sck_rise) begin
         sh_q <= byte_in;
         bit_q <= bit_q + 3'h1;
         if (byte_done && nbytes_q != 3'h4)
            nbytes_q <= nbytes_q + 3'h1;
      end
   end

   // First byte is the command, next three the address
   always_ff @(posedge clk) begin
      if (srst) begin
         opc_q <= 8'h00;
         addr_q <= 24'h000000;
      end else if (byte_done) begin
         if (nbytes_q == 3'h0)
            opc_q <= byte_in;
         else if (nbytes_q <= 3'(`FES_ADDR_BYTES))
            addr_q <= {addr_q[15:0], byte_in};
      end
   end

   // ----------------------------------------
   // Command decode at deselect
   // ----------------------------------------
   fes_state_e st_q;
   logic wen_q, err_flag_q, prg_susp_q, ers_susp_q, run_prg_q;
   logic [31:0] cnt_q, ers_rem_q, prg_rem_q;
   logic [SW-1:0] ers_sec_q, prg_sec_q;

   wire aligned = (bit_q == 3'h0);
   wire have_op = aligned & (nbytes_q != 3'h0);
   wire have_addr = aligned & (nbytes_q == 3'h4);
   wire idle = (st_q == ST_IDLE);
   wire any_susp = prg_susp_q | ers_susp_q;
   wire is_4k = (opc_q == `FES_CMD_ERASE_4K);
   wire is_32k = (opc_q == `FES_CMD_ERASE_32K);
   wire is_64k = (opc_q == `FES_CMD_ERASE_64K);
   wire is_blk = (nbytes_q != 3'h0) & (is_4k | is_32k | is_64k);
   wire is_chip = (nbytes_q != 3'h0) &
      ((opc_q == `FES_CMD_CHIP_A) | (opc_q == `FES_CMD_CHIP_B));
   wire is_susp = have_op & (opc_q == `FES_CMD_SUSPEND);
   wire is_res = have_op & (opc_q == `FES_CMD_RESUME);
   wire [SW-1:0] cmd_sec = addr_q[`FES_SECTOR_LSB +: SW];
   wire blk_hits_prg = prg_susp_q & have_addr & (cmd_sec == prg_sec_q);

   // Erase commands: program-suspended target, then suspend, then checks
   wire blk_go = cs_rise & is_blk & idle & ~any_susp;
   wire blk_clr = (cs_rise & is_blk & blk_hits_prg) |
      (blk_go & (~have_addr | (wen_q & sector_protected[cmd_sec])));
   wire blk_start = blk_go & have_addr & wen_q & ~sector_protected[cmd_sec];
   wire chip_go = cs_rise & is_chip & idle & ~any_susp;
   wire chip_clr = chip_go & (~aligned | (wen_q & (|sector_protected)));
   wire chip_start = chip_go & aligned & wen_q & ~(|sector_protected);
   wire ers_start = blk_start | chip_start;

   // Suspend only while an operation is actually running
   wire susp_go = cs_rise & is_susp & (st_q == ST_RUN);
   wire res_go = cs_rise & is_res & idle & any_susp;
   wire res_prg = prg_susp_q;

   // Program requests from the program command path
   wire [SW-1:0] prg_sec = prog_addr[`FES_SECTOR_LSB +: SW];
   wire prg_ok = prog_start & idle & ~prg_susp_q & ~ers_start & ~res_go;
   wire prg_hit_ers = prg_ok & ers_susp_q & (prg_sec == ers_sec_q);
   wire prg_start = prg_ok & ~prg_hit_ers;

   // Erase base and kind, low address bits dropped per size
   wire [23:0] blk_mask = is_4k ? `FES_MASK_4K :
      (is_32k ? `FES_MASK_32K : `FES_MASK_64K);
   wire [23:0] ers_base = chip_start ? 24'h000000 : (addr_q & blk_mask);
   wire fes_kind_e ers_kind = chip_start ? KIND_CHIP :
      (is_4k ? KIND_4K : (is_32k ? KIND_32K : KIND_64K));
   wire [31:0] ers_cyc = chip_start ? 32'(CHIP_ERASE_CYC) : 32'(BLK_ERASE_CYC);

   // ----------------------------------------
   // Write enable latch
   // ----------------------------------------
   // Cleared on aborts and at the start of every array cycle
   wire wen_clr = blk_clr | chip_clr | prg_hit_ers | ers_start | prg_start;
   wire wen_ok = wen_set & idle & ~prg_susp_q;

   always_ff @(posedge clk) begin
      if (srst)
         wen_q <= 1'b0;
      else if (wen_clr)
         wen_q <= 1'b0;
      else if (wen_ok)
         wen_q <= 1'b1;
   end

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   wire cnt_end = (cnt_q == 32'h1);
   wire [31:0] rem = run_prg_q ? prg_rem_q : ers_rem_q;
   wire run_end = (st_q == ST_RUN) & (rem == 32'h1);

   always_ff @(posedge clk) begin
      if (srst) begin
         st_q <= ST_IDLE;
         run_prg_q <= 1'b0;
         cnt_q <= 32'h0;
      end else begin
         unique case (st_q)
            ST_IDLE: begin
               if (ers_start || prg_start) begin
                  st_q <= ST_RUN;
                  run_prg_q <= prg_start;
               end else if (res_go) begin
                  st_q <= ST_RES_WAIT;
                  run_prg_q <= res_prg;
                  cnt_q <= 32'(RES_CYC);
               end
            end
            ST_RUN: begin
               if (susp_go) begin
                  st_q <= ST_SUSP_WAIT;
                  cnt_q <= 32'(SUSP_CYC);
               end else if (run_end)
                  st_q <= ST_IDLE;
            end
            ST_SUSP_WAIT: begin
               cnt_q <= cnt_q - 32'h1;
               if (cnt_end)
                  st_q <= ST_IDLE;
            end
            ST_RES_WAIT: begin
               cnt_q <= cnt_q - 32'h1;
               if (cnt_end)
                  st_q <= ST_RUN;
            end
         endcase
      end
   end

   // Remaining cycle counts survive a suspend
   always_ff @(posedge clk) begin
      if (srst) begin
         ers_rem_q <= 32'h0;
         prg_rem_q <= 32'h0;
         ers_sec_q <= '0;
         prg_sec_q <= '0;
      end else if (ers_start) begin
         ers_rem_q <= ers_cyc;
         ers_sec_q <= cmd_sec;
      end else if (prg_start) begin
         prg_rem_q <= 32'(PROG_CYC);
         prg_sec_q <= prg_sec;
      end else if (st_q == ST_RUN && !susp_go) begin
         if (run_prg_q)
            prg_rem_q <= prg_rem_q - 32'h1;
         else
            ers_rem_q <= ers_rem_q - 32'h1;
      end
   end

   // Suspend flags and error flag
   wire susp_done = (st_q == ST_SUSP_WAIT) & cnt_end;
   wire res_done = (st_q == ST_RES_WAIT) & cnt_end;

   always_ff @(posedge clk) begin
      if (srst) begin
         prg_susp_q <= 1'b0;
         ers_susp_q <= 1'b0;
         err_flag_q <= 1'b0;
      end else begin
         if (susp_done && run_prg_q)
            prg_susp_q <= 1'b1;
         else if (res_done && run_prg_q)
            prg_susp_q <= 1'b0;
         if (susp_done && !run_prg_q)
            ers_susp_q <= 1'b1;
         else if (res_done && !run_prg_q)
            ers_susp_q <= 1'b0;
         if (ers_start || prg_start)
            err_flag_q <= 1'b0;
         else if (run_end)
            err_flag_q <= array_fail;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   wire [SW-1:0] rd_sec = rd_addr[`FES_SECTOR_LSB +: SW];
   wire rd_bad = (ers_susp_q & (rd_sec == ers_sec_q)) | (prg_susp_q & (rd_sec == prg_sec_q));

   // Registered strobes toward the array and the read path
   always_ff @(posedge clk) begin
      if (srst) begin
         erase_cmd <= '0;
         prog_abort <= 1'b0;
         rd_undefined <= 1'b0;
      end else begin
         erase_cmd.valid <= ers_start;
         if (ers_start) begin
            erase_cmd.kind <= ers_kind;
            erase_cmd.addr <= ers_base;
         end
         prog_abort <= prg_hit_ers;
         rd_undefined <= rd_bad;
      end
   end

   // Status fields straight from the state and flag registers
   assign status.ready_busy_flag = ~idle;
   assign status.write_enable_latch = wen_q;
   assign status.erase_program_error_flag = err_flag_q;
   assign status.program_suspended_flag = prg_susp_q;
   assign status.erase_suspended_flag = ers_susp_q;

endmodule : fes_erase_suspend

// *** testbench/fes_spi_host.sv ***
`timescale 1ns/1ns
// ---------------------------------
// Serial host model
// ---------------------------------
module fes_spi_host (
   input wire logic clk,
   output logic cs_n,
   output logic sck,
   output logic si
);
   // Link idles deselected with the clock low
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      si = 1'b0;
   end
   // Shifts the top nbits of d out, MSB first, eight clk per bit
   task automatic frame(input logic [39:0] d, input int nbits);
      @(posedge clk);
      cs_n <= 1'b0;
      for (int i = 0; i < nbits; i++) begin
         si <= d[39-i];
         repeat (4) @(posedge clk);
         sck <= 1'b1;
         repeat (4) @(posedge clk);
         sck <= 1'b0;
      end
      repeat (4) @(posedge clk);
      cs_n <= 1'b1;
      si <= ~si; // Released line holds no stale value
      repeat (6) @(posedge clk);
   endtask : frame
endmodule : fes_spi_host

// *** testbench/fes_erase_suspend_sva.sv ***
`timescale 1ns/1ns
// ---------------------------------
// Port checker
// ---------------------------------
module fes_erase_suspend_sva
import fes_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [31:0] sector_protected,
   input wire logic prog_start,
   input wire logic array_fail,
   input wire fes_pkg::fes_status_s status,
   input wire fes_pkg::fes_erase_cmd_s erase_cmd,
   input wire logic prog_abort,
   input wire logic rd_undefined
);
   // Short names for the erase order fields and the status flags
   wire ev = erase_cmd.valid;
   wire [23:0] ea = erase_cmd.addr;
   wire busy = status.ready_busy_flag;
   wire wen = status.write_enable_latch;
   wire prg_susp = status.program_suspended_flag;
   wire ers_susp = status.erase_suspended_flag;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   a_start_busy: assert property (ev |-> busy && !wen)
      else $error("erase start without busy");
   a_start_latch: assert property (ev |-> $past(wen) && !$past(busy))
      else $error("erase started without latch");
   a_block_base: assert property (ev && erase_cmd.kind != KIND_CHIP |->
      ea[11:0] == 12'h000 && (erase_cmd.kind == KIND_4K || ea[14:12] == 3'h0)
      && (erase_cmd.kind != KIND_64K || !ea[15])) else $error("block base not masked");
   a_block_prot: assert property (ev && erase_cmd.kind != KIND_CHIP |->
      !sector_protected[ea[20:16]]) else $error("protected block erased");
   a_chip_prot: assert property (ev && erase_cmd.kind == KIND_CHIP |->
      sector_protected == 32'h0 && ea == 24'h0) else $error("chip erase wrong");
   a_abort_src: assert property (prog_abort |-> $past(prog_start) && ers_susp ##1 !wen)
      else $error("program abort wrong");
   a_undef_src: assert property (rd_undefined |-> $past(prg_susp || ers_susp))
      else $error("undefined read with no suspend");
   a_susp_ready: assert property ($rose(ers_susp) || $rose(prg_susp) |-> !busy)
      else $error("suspended but busy");
   a_resume_order: assert property ($fell(ers_susp) |-> !prg_susp)
      else $error("erase resumed before program");
   a_err_flag: assert property ($fell(busy) && !prg_susp && !ers_susp |->
      status.erase_program_error_flag == $past(array_fail)) else $error("error flag wrong");
   c_chip: cover property (ev && erase_cmd.kind == KIND_CHIP);
   c_both: cover property (prg_susp && ers_susp);
   c_abort: cover property (prog_abort);
endmodule : fes_erase_suspend_sva
bind fes_erase_suspend fes_erase_suspend_sva u_sva (.clk, .srst, .sector_protected,
   .prog_start, .array_fail, .status, .erase_cmd, .prog_abort, .rd_undefined);

// *** testbench/fes_erase_suspend_tb.sv ***
`timescale 1ns/1ns
`include "fes_params.svh"
// ---------------------------------
// Sequencer testbench
// ---------------------------------
module fes_erase_suspend_tb;
   import fes_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic cs_n, sck, si, prog_abort, rd_undefined, ef;
   logic [31:0] prot = 32'h0;
   logic wen_set = 1'b0;
   logic prog_start = 1'b0;
   logic array_fail = 1'b0;
   logic [23:0] prog_addr = 24'h0;
   logic [23:0] rd_addr = 24'h0;
   logic [23:0] a;
   fes_status_s status;
   fes_erase_cmd_s erase_cmd;
   int errors = 0;
   int checks_done = 0;
   int cyc = 0;
   fes_erase_cmd_s exq[$];
   logic abq[$];
   logic [7:0] ops[5] = '{8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7};
   fes_kind_e ks[5] = '{KIND_4K, KIND_32K, KIND_64K, KIND_CHIP, KIND_CHIP};
   logic [23:0] ms[5] = '{`FES_MASK_4K, `FES_MASK_32K, `FES_MASK_64K, 24'h0, 24'h0};
   int nbs[5] = '{32, 32, 32, 16, 16};
   logic [7:0] ao[5] = '{8'h20, 8'h20, 8'h52, 8'hc7, 8'h60};
   int an[5] = '{24, 33, 32, 8, 9};
   always #50 clk = ~clk;
   fes_erase_suspend #(.BLK_ERASE_CYC(400), .CHIP_ERASE_CYC(40), .PROG_CYC(300)) DUT (
      .clk(clk), .srst(srst), .cs_n_pin(cs_n), .sck_pin(sck), .si_pin(si),
      .sector_protected(prot), .wen_set(wen_set), .prog_start(prog_start),
      .prog_addr(prog_addr), .array_fail(array_fail), .rd_addr(rd_addr),
      .status(status), .erase_cmd(erase_cmd), .prog_abort(prog_abort),
      .rd_undefined(rd_undefined));
   fes_spi_host host (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si));
   // ---------------------------------
   // Helpers
   // ---------------------------------
   task automatic fail(input string m);
      errors++;
      $display("[ERR] %0t %s", $time, m);
   endtask : fail
   task automatic chk(input logic [4:0] got, input logic [4:0] exp);
      checks_done++;
      if (got !== exp) fail($sformatf("got %b expected %b", got, exp));
   endtask : chk
   task automatic complete_run();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : complete_run
   task automatic pulse_wen();
      @(posedge clk);
      wen_set <= 1'b1;
      @(posedge clk);
      wen_set <= 1'b0;
   endtask : pulse_wen
   task automatic prog(input logic [23:0] pa);
      @(posedge clk);
      prog_addr <= pa;
      prog_start <= 1'b1;
      @(posedge clk);
      prog_start <= 1'b0;
   endtask : prog
   task automatic wait_idle();
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (status.ready_busy_flag !== 1'b0 && n < 3000);
      if (n >= 3000) fail("busy never dropped");
   endtask : wait_idle
   task automatic rd(input logic [23:0] ra, input logic exp);
      @(posedge clk);
      rd_addr <= ra;
      repeat (3) @(negedge clk);
      chk({4'h0, rd_undefined}, {4'h0, exp});
   endtask : rd
   // Takes the oldest note off a queue whenever a result appears
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail("timeout");
         complete_run();
      end
      if (erase_cmd.valid === 1'b1) begin
         checks_done++;
         if (exq.size() == 0 || erase_cmd !== exq.pop_front()) fail("erase order wrong");
      end
      if (prog_abort === 1'b1) begin
         checks_done++;
         if (abq.size() == 0) fail("unexpected abort");
         else void'(abq.pop_front());
      end
   end
   // ---------------------------------
   // Scenarios
   // ---------------------------------
   initial begin
      void'($urandom(33266));
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      repeat (4) @(posedge clk);
      for (int i = 0; i < 5; i++) begin
         a = 24'($urandom()) & 24'h1fffff;
         pulse_wen();
         ef = 1'($urandom());
         array_fail <= ef;
         exq.push_back('{1'b1, ks[i], a & ms[i]});
         host.frame({ops[i], a, 8'h00}, nbs[i]);
         wait_idle();
         chk(status, {2'b00, ef, 2'b00});
      end
      host.frame({8'h20, a, 8'h00}, 32);
      repeat (10) @(negedge clk);
      chk(status, {2'b00, ef, 2'b00});
      $display("test erase codes done");
      for (int i = 0; i < 5; i++) begin
         pulse_wen();
         prot <= (i == 2 || i == 3) ? 32'h10 : 32'h0;
         host.frame({ao[i], 24'h04a5c3, 8'h00}, an[i]);
         repeat (10) @(negedge clk);
         chk(status, {2'b00, ef, 2'b00});
      end
      $display("test refused erases done");
      pulse_wen();
      prot <= 32'h0;
      exq.push_back('{1'b1, KIND_64K, 24'h030000});
      host.frame({8'hd8, 24'h03ffff, 8'h00}, 32);
      host.frame({8'hb0, 32'h0}, 9);
      @(negedge clk);
      chk(status, 5'b10000);
      host.frame({8'hb0, 32'hffffffff}, 16);
      wait_idle();
      chk(status, 5'b00001);
      rd(24'h03fffe, 1'b1);
      rd(24'h040000, 1'b0);
      $display("test suspend done");
      pulse_wen();
      host.frame({8'h20, 24'h040000, 8'h00}, 32);
      repeat (10) @(negedge clk);
      chk(status, 5'b01001);
      abq.push_back(1'b1);
      prog(24'h031000);
      repeat (4) @(negedge clk);
      chk(status, 5'b00001);
      prog(24'h050000);
      host.frame({8'hb0, 32'h0}, 8);
      wait_idle();
      chk(status, 5'b00011);
      host.frame({8'h20, 24'h050000, 8'h00}, 32);
      repeat (10) @(negedge clk);
      chk(status, 5'b00011);
      host.frame({8'hd0, 32'h0}, 8);
      wait_idle();
      chk(status, {2'b00, ef, 2'b01});
      host.frame({8'hd0, 32'h0}, 8);
      wait_idle();
      chk(status, {2'b00, ef, 2'b00});
      $display("test resume done");
      checks_done++;
      if (exq.size() != 0 || abq.size() != 0) fail("result missing");
      complete_run();
   end
endmodule : fes_erase_suspend_tb
